// [rtl/shutdown_status_pkg.sv]
// Command codes, field layout and timing constants of the shutdown/status bank
package shutdown_status_pkg;
  // Command codes
  localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_TURN_OFF_FALL_TIME = 8'h65;
  localparam logic [7:0] CMD_STATUS_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_SUMMARY_WORD = 8'h79;
  // Reset values
  localparam logic [15:0] TURN_OFF_DELAY_RST = 16'hca80;
  localparam logic [15:0] TURN_OFF_FALL_RST = 16'hca80;
  localparam logic [15:0] STATUS_WORD_RST = 16'h0000;
  // Linear-11 field layout
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;
  // Status summary bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_OUTPUT_VOLTAGE_SUMMARY_OV = 5;
  localparam int SB_OUTPUT_CURRENT_SUMMARY_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SW_OUTPUT_VOLTAGE_SUMMARY = 15;
  localparam int SW_OUTPUT_CURRENT_SUMMARY = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_VENDOR = 12;
  localparam int SW_PG_N = 11;
  localparam int SW_OTHER = 9;
  // Bit positions inside the detailed status bytes
  localparam int DV_OV_FAULT = 7;
  localparam int DI_OC_FAULT = 7;
  localparam int DIN_UV_FAULT = 4;
  // Timing: internal time unit is 1/16 ms
  localparam int FRAC_BITS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 62500;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int UNITS_PER_MS = 1 << FRAC_BITS;
  localparam int DELAY_MAX_MS = 5000;
  localparam int FALL_MIN_MS = 5;
  localparam int FALL_MAX_MS = 100;
  localparam int UNIT_W = 24;
  localparam logic [UNIT_W-1:0] DELAY_MAX_UNITS =
    UNIT_W'(DELAY_MAX_MS * UNITS_PER_MS);
  localparam logic [UNIT_W-1:0] FALL_MIN_UNITS =
    UNIT_W'(FALL_MIN_MS * UNITS_PER_MS);
  localparam logic [UNIT_W-1:0] FALL_MAX_UNITS =
    UNIT_W'(FALL_MAX_MS * UNITS_PER_MS);
endpackage

// [rtl/linear11_decode.sv]
// Converts a linear-11 millisecond code into 1/16 ms time units
`timescale 1ns/100ps
module linear11_decode import shutdown_status_pkg::*; #(
  parameter int OUT_W = UNIT_W
) (
  input wire logic [15:0] code,
  output logic [OUT_W-1:0] units
);
  logic signed [4:0] exp_n;
  logic signed [10:0] mant_y;
  logic signed [6:0] shift;
  logic [47:0] wide;

  // The shifter is 48 bits wide; wider outputs cannot be served
  generate
    if (OUT_W < 1 || OUT_W > 48) begin : g_bad_width
      $error("OUT_W must lie between 1 and 48");
    end
  endgenerate

  // Y times 2^N ms, scaled to 2^-FRAC_BITS ms; negative Y reads as zero
  always_comb begin
    exp_n = code[EXP_MSB:EXP_LSB]; // R2
    mant_y = code[MANT_MSB:0]; // R2
    shift = 7'(exp_n) + 7'(FRAC_BITS);
    wide = 48'h0;
    if (!mant_y[10]) begin
      if (shift >= 0) begin
        wide = 48'(mant_y[9:0]) << shift[4:0];
      end else begin
        wide = 48'(mant_y[9:0]) >> 7'(-shift);
      end
    end
    if (wide > 48'({OUT_W{1'b1}})) begin
      units = {OUT_W{1'b1}};
    end else begin
      units = wide[OUT_W-1:0];
    end
  end
endmodule // linear11_decode

// [rtl/shutdown_status_regs.sv]
// Turn-off timing registers, shutdown sequencer and status summaries
//
// Contract
// R1 - Hold 16-bit turn-off delay: disable event to start of output fall.
// R2 - Timing codes: signed exponent bits 15:11, signed mantissa, Y*2^N ms.
// R3 - Turn-off delay resets to 5 ms code; range zero to five seconds.
// R4 - Hold 16-bit fall time; ramp applied only in single two-phase mode.
// R5 - Fall time below 5 ms: switch off both switches when delay expires.
// R6 - In 4, 6 or 8 phase group always switch off at delay expiry.
// R7 - Fall time resets to 5 ms code; range five to one hundred ms.
// R8 - Status byte equals the low byte of the status word.
// R9 - Bit 7: fault declared because device was busy.
// R10 - Bit 6: output not powered, for any reason including not enabled.
// R11 - Bits 5,4,3: output overvoltage, output overcurrent, input undervoltage.
// R12 - Bit 2 temperature, bit 1 comm/memory/logic, bit 0 unused.
// R13 - Read-only status word resets to all zeros; it reads 0x0840 after reset here (bit 6 off, bit 11 power-good negated).
// R14 - Word bits 15..12 summarise output V, output I, input, vendor.
// R15 - Word bit 11 set while power-good is negated.
// R16 - Word bit 9 set if any detailed status bit set; 10, 8 unused.
// R17 - Latched faults clear only on clear-faults command, not on read.
// R18 - Power-good on above on-threshold, off below undervoltage limit.
// R19 - Writes to either status summary register are ignored.
// R20 - Summary bits are combinational ORs of latched detailed bits.
`timescale 1ns/100ps
module shutdown_status_regs import shutdown_status_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int VOLT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_unknown,
  input wire logic clear_faults,
  input wire logic output_enable,
  input wire logic multi_phase,
  input wire logic busy_event,
  input wire logic [7:0] output_voltage_summary_status,
  input wire logic [7:0] output_current_summary_status,
  input wire logic [7:0] input_status,
  input wire logic [7:0] temp_status,
  input wire logic [7:0] cml_status,
  input wire logic [7:0] vendor_detail_status,
  input wire logic [VOLT_W-1:0] output_voltage_summary_meas,
  input wire logic [VOLT_W-1:0] power_good_on,
  input wire logic [VOLT_W-1:0] output_undervoltage_limit,
  output logic power_good,
  output logic ramp_active,
  output logic switches_off,
  output logic output_off
);
  localparam int TW = $clog2(TICK_LEN + 1);

  generate
    if (TICK_LEN < 1 || VOLT_W < 1) begin : g_bad_param
      $error("TICK_LEN and VOLT_W must be at least one");
    end
  endgenerate

  typedef enum logic [1:0] {ST_ON, ST_DELAY, ST_FALL, ST_OFF} seq_e;

  typedef struct packed {
    seq_e st;
    logic [UNIT_W-1:0] elapsed;
    logic [TW-1:0] tick_cnt;
    logic [15:0] delay;
    logic [15:0] fall;
    logic busy;
    logic pg;
    logic [15:0] rdata;
    logic rvalid;
    logic unknown;
    logic sw_off;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic [UNIT_W-1:0] delay_units;
  logic [UNIT_W-1:0] fall_units;
  logic [UNIT_W-1:0] delay_target;
  logic [UNIT_W-1:0] fall_target;
  logic fall_short;
  logic tick;
  logic [15:0] status_word;
  logic [7:0] status_byte;
  logic output_overvoltage_fault;
  logic output_overcurrent_fault;
  logic input_undervoltage_fault;
  logic comm_memory_logic_summary;
  logic output_voltage_summary;
  logic output_current_summary;
  logic vendor_specific_summary;
  logic other_summary;

  // Decode both timing codes into time units
  linear11_decode #(.OUT_W(UNIT_W)) u_delay_dec (
    .code(state_r.delay),
    .units(delay_units)
  );
  linear11_decode #(.OUT_W(UNIT_W)) u_fall_dec (
    .code(state_r.fall),
    .units(fall_units)
  );

  // Clamp delay and fall time to their maximums; flag fall times below the minimum
  always_comb begin
    delay_target = (delay_units > DELAY_MAX_UNITS) ?
      DELAY_MAX_UNITS : delay_units; // R3
    fall_short = fall_units < FALL_MIN_UNITS; // R5
    fall_target = (fall_units > FALL_MAX_UNITS) ?
      FALL_MAX_UNITS : fall_units; // R7
  end

  // Summary bits from the latched detailed registers
  always_comb begin
    output_overvoltage_fault = output_voltage_summary_status[DV_OV_FAULT]; // R11
    output_overcurrent_fault = output_current_summary_status[DI_OC_FAULT]; // R11
    input_undervoltage_fault = input_status[DIN_UV_FAULT]; // R11
    comm_memory_logic_summary = |cml_status; // R12
    output_voltage_summary = |output_voltage_summary_status; // R14
    output_current_summary = |output_current_summary_status; // R14
    vendor_specific_summary = |vendor_detail_status; // R14
    other_summary = |{output_voltage_summary_status, output_current_summary_status, input_status,
                      temp_status, cml_status, vendor_detail_status}; // R16
    status_word = STATUS_WORD_RST; // R13 R20
    status_word[SB_BUSY] = state_r.busy; // R9
    status_word[SB_OFF] = state_r.st == ST_OFF; // R10
    status_word[SB_OUTPUT_VOLTAGE_SUMMARY_OV] = output_overvoltage_fault; // R11
    status_word[SB_OUTPUT_CURRENT_SUMMARY_OC] = output_overcurrent_fault; // R11
    status_word[SB_VIN_UV] = input_undervoltage_fault; // R11
    status_word[SB_TEMP] = |temp_status; // R12
    status_word[SB_CML] = comm_memory_logic_summary; // R12
    status_word[SW_OUTPUT_VOLTAGE_SUMMARY] = output_voltage_summary; // R14
    status_word[SW_OUTPUT_CURRENT_SUMMARY] = output_current_summary; // R14
    status_word[SW_INPUT] = |input_status; // R14
    status_word[SW_VENDOR] = vendor_specific_summary; // R14
    status_word[SW_PG_N] = !state_r.pg; // R15
    status_word[SW_OTHER] = other_summary; // R16
    status_byte = status_word[7:0]; // R8
  end

  assign tick = state_r.tick_cnt == TW'(TICK_LEN - 1);

  // Next-state logic for registers, sequencer and read port
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.unknown = 1'b0;
    // Writes; status summaries silently ignore them
    if (cmd_wr) begin
      case (cmd_code)
        CMD_TURN_OFF_DELAY: state_nxt.delay = cmd_wdata; // R1
        CMD_TURN_OFF_FALL_TIME: state_nxt.fall = cmd_wdata; // R4
        CMD_STATUS_SUMMARY_BYTE, CMD_STATUS_SUMMARY_WORD: begin
          state_nxt.unknown = 1'b0; // R19
        end
        default: state_nxt.unknown = 1'b1;
      endcase
    end
    // Reads have no side effect on any latched bit
    if (cmd_rd) begin
      state_nxt.rvalid = 1'b1;
      case (cmd_code)
        CMD_TURN_OFF_DELAY: state_nxt.rdata = state_r.delay;
        CMD_TURN_OFF_FALL_TIME: state_nxt.rdata = state_r.fall;
        CMD_STATUS_SUMMARY_BYTE: state_nxt.rdata = {8'h00, status_byte};
        CMD_STATUS_SUMMARY_WORD: state_nxt.rdata = status_word;
        default: begin
          state_nxt.rdata = 16'h0000;
          state_nxt.unknown = 1'b1;
        end
      endcase
    end
    // Busy fault: set wins over clear-faults
    if (busy_event) begin
      state_nxt.busy = 1'b1; // R9
    end else if (clear_faults) begin
      state_nxt.busy = 1'b0; // R17
    end
    // Power-good hysteresis
    if (output_voltage_summary_meas > power_good_on) begin
      state_nxt.pg = 1'b1; // R18
    end else if (output_voltage_summary_meas < output_undervoltage_limit) begin
      state_nxt.pg = 1'b0; // R18
    end
    // Time base in 1/16 ms steps
    state_nxt.tick_cnt = tick ? '0 : state_r.tick_cnt + TW'(1);
    if (tick) begin
      state_nxt.elapsed = state_r.elapsed + UNIT_W'(1);
    end
    // Shutdown sequencer
    case (state_r.st)
      ST_ON: begin
        state_nxt.sw_off = 1'b0;
        if (!output_enable) begin
          state_nxt.st = ST_DELAY;
          state_nxt.elapsed = '0;
          state_nxt.tick_cnt = '0;
        end
      end
      ST_DELAY: begin
        if (output_enable) begin
          state_nxt.st = ST_ON;
        end else if (state_r.elapsed >= delay_target) begin // R1
          state_nxt.elapsed = '0;
          state_nxt.tick_cnt = '0;
          if (multi_phase || fall_short) begin
            state_nxt.st = ST_OFF; // R5 R6
            state_nxt.sw_off = 1'b1;
          end else begin
            state_nxt.st = ST_FALL; // R4
          end
        end
      end
      ST_FALL: begin
        if (output_enable) begin
          state_nxt.st = ST_ON;
        end else if (state_r.elapsed >= fall_target) begin // R4
          state_nxt.st = ST_OFF;
          state_nxt.sw_off = 1'b1;
        end
      end
      ST_OFF: begin
        if (output_enable) begin
          state_nxt.st = ST_ON;
          state_nxt.sw_off = 1'b0;
        end
      end
      default: state_nxt.st = ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= '0;
      state_r.st <= ST_OFF;
      state_r.delay <= TURN_OFF_DELAY_RST; // R3
      state_r.fall <= TURN_OFF_FALL_RST; // R7
      state_r.sw_off <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  assign cmd_rdata = state_r.rdata;
  assign cmd_rvalid = state_r.rvalid;
  assign cmd_unknown = state_r.unknown;
  assign power_good = state_r.pg;
  assign ramp_active = state_r.st == ST_FALL;
  assign switches_off = state_r.sw_off;
  assign output_off = state_r.st == ST_OFF;

  // Checks on read port, status bits and sequencer
  a_byte_mirror: assert property (@(posedge clk) disable iff (!rstn) // R8
    cmd_rd && cmd_code == CMD_STATUS_SUMMARY_BYTE |=>
    cmd_rdata == {8'h00, $past(status_word[7:0])})
    else $error("status byte differs from word low byte");
  a_word_read: assert property (@(posedge clk) disable iff (!rstn) // R16
    cmd_rd && cmd_code == CMD_STATUS_SUMMARY_WORD |=>
    cmd_rvalid && cmd_rdata[10] == 1'b0 && cmd_rdata[8] == 1'b0 &&
    cmd_rdata[0] == 1'b0)
    else $error("unused status word bits set");
  a_off_bit: assert property (@(posedge clk) disable iff (!rstn) // R10
    switches_off |-> status_word[SB_OFF])
    else $error("off bit clear while switches are off");
  a_pg_bit: assert property (@(posedge clk) disable iff (!rstn) // R15
    output_voltage_summary_meas < output_undervoltage_limit |=> status_word[SW_PG_N])
    else $error("power-good bit not set below undervoltage limit");
  a_busy_sticky: assert property (@(posedge clk) disable iff (!rstn) // R9
    busy_event || (status_word[SB_BUSY] && !clear_faults) |=>
    status_word[SB_BUSY])
    else $error("busy fault lost before clear");
  a_busy_clear: assert property (@(posedge clk) disable iff (!rstn) // R17
    clear_faults && !busy_event |=> !status_word[SB_BUSY])
    else $error("busy fault survived clear-faults");
  a_status_wr_ign: assert property (@(posedge clk) disable iff (!rstn) // R19
    cmd_wr && (cmd_code == CMD_STATUS_SUMMARY_WORD ||
    cmd_code == CMD_STATUS_SUMMARY_BYTE) |=>
    $stable(state_r.delay) && $stable(state_r.fall) && !cmd_unknown)
    else $error("status write had an effect");
  a_multi_cut: assert property (@(posedge clk) disable iff (!rstn) // R6
    multi_phase && state_r.st == ST_DELAY && !output_enable &&
    state_r.elapsed >= delay_target |=> switches_off && !ramp_active)
    else $error("multi-phase shutdown not immediate");
  a_short_fall: assert property (@(posedge clk) disable iff (!rstn) // R5
    fall_short && state_r.st == ST_DELAY && !output_enable &&
    state_r.elapsed >= delay_target |=> output_off)
    else $error("short fall time still ramped");
  a_delay_hold: assert property (@(posedge clk) disable iff (!rstn) // R1
    state_r.st == ST_DELAY && state_r.elapsed < delay_target &&
    !output_enable |=> state_r.st == ST_DELAY)
    else $error("delay ended early");
  a_fall_ramp: assert property (@(posedge clk) disable iff (!rstn) // R4
    !multi_phase && !fall_short && state_r.st == ST_DELAY &&
    !output_enable && state_r.elapsed >= delay_target |=> ramp_active)
    else $error("single two-phase shutdown skipped the ramp");
  a_abort_seq: assert property (@(posedge clk) disable iff (!rstn) // R1
    output_enable && (state_r.st == ST_DELAY || state_r.st == ST_FALL)
    |=> !output_off && !switches_off && !ramp_active)
    else $error("enable during shutdown did not return to on");
endmodule // shutdown_status_regs

// [dv/host_model.sv]
// Host side model driving the command port of the shutdown/status bank
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic [15:0] cmd_wdata,
  output logic cmd_rd,
  output logic clear_faults,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_unknown
);
  // Idle port at time zero
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
    cmd_rd = 1'b0;
    clear_faults = 1'b0;
  end

  // One write, held across one rising edge
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd_code = code;
    cmd_wdata = data;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~data; // Released data shows no stale value
  endtask

  // One read; answer is sampled half a cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [15:0] data,
                    output logic unk, output logic vld);
    @(negedge clk);
    cmd_code = code;
    cmd_rd = 1'b1;
    @(negedge clk);
    cmd_rd = 1'b0;
    data = cmd_rdata;
    unk = cmd_unknown;
    vld = cmd_rvalid;
  endtask

  // Clear-faults command pulse, the only way besides reset that latched bits are cleared
  task automatic clr();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask
endmodule // host_model

// [dv/shutdown_status_regs_tb_top.sv]
// Self-checking bench for the shutdown timing and status summary bank
`timescale 1ns/100ps
module shutdown_status_regs_tb_top import shutdown_status_pkg::*;;
  localparam int DLY = 64;
  localparam int FALL5 = 160;
  logic clk, rstn, cmd_wr, cmd_rd, cmd_rvalid, cmd_unknown, clear_faults;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, output_voltage_summary_meas, rd_d;
  logic output_enable, multi_phase, busy_event, power_good;
  logic ramp_active, switches_off, output_off, rd_u, rd_v;
  logic [7:0] st [6];
  int miscompares = 0;
  int total_checks = 0;

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  shutdown_status_regs #(.TICK_LEN(2), .VOLT_W(16)) DUT (
    .clk(clk), .rstn(rstn), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_unknown(cmd_unknown),
    .clear_faults(clear_faults), .output_enable(output_enable),
    .multi_phase(multi_phase), .busy_event(busy_event),
    .output_voltage_summary_status(st[0]), .output_current_summary_status(st[1]), .input_status(st[2]),
    .temp_status(st[3]), .cml_status(st[4]),
    .vendor_detail_status(st[5]), .output_voltage_summary_meas(output_voltage_summary_meas),
    .power_good_on(16'h0050), .output_undervoltage_limit(16'h0032),
    .power_good(power_good), .ramp_active(ramp_active),
    .switches_off(switches_off), .output_off(output_off));

  host_model host (
    .clk(clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .clear_faults(clear_faults),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_unknown(cmd_unknown));

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Read one command and compare data and answer strobe
  task automatic rc(input logic [7:0] code, input logic [15:0] exp);
    host.rd(code, rd_d, rd_u, rd_v);
    chk(rd_d, exp);
    chk({14'h0000, rd_u, rd_v}, 16'h0001);
  endtask

  // Bounded wait for switches_off, or for either shutdown output when any is set; returns cycles waited
  task automatic wait_off(input logic any, output int n);
    n = 0;
    while (switches_off !== 1'b1 && (!any || ramp_active !== 1'b1)) begin
      @(negedge clk);
      n++;
      if (n >= 400) begin
        miscompares++;
        complete_run();
      end
    end
  endtask

  // Enable, then disable and time the turn-off sequence
  task automatic sd(input logic mp, input logic [15:0] fall,
                    input logic rp);
    int n;
    host.wr(CMD_TURN_OFF_FALL_TIME, fall);
    multi_phase = mp;
    output_enable = 1'b1;
    output_voltage_summary_meas = 16'h0064;
    repeat (4) @(negedge clk);
    rc(CMD_STATUS_SUMMARY_WORD, 16'h0000);
    output_voltage_summary_meas = 16'h0040;
    repeat (2) @(negedge clk);
    chk({15'h0000, power_good}, 16'h0001);
    output_enable = 1'b0;
    wait_off(1'b1, n);
    chk(16'(n >= DLY && n <= DLY + 3), 16'h0001);
    chk({15'h0000, ramp_active}, {15'h0000, rp});
    if (rp) begin
      wait_off(1'b0, n);
      chk(16'(n >= FALL5 - 3 && n <= FALL5 + 3), 16'h0001);
    end
    output_voltage_summary_meas = 16'h0000;
    repeat (3) @(negedge clk);
    chk({14'h0000, output_off, power_good}, 16'h0002);
    $display("test shutdown mp=%0d fall=%h done", mp, fall);
  endtask

  // Status pattern per detailed byte and its summary word
  logic [7:0] pat [6] = '{8'h80, 8'h80, 8'h10, 8'h01, 8'h02, 8'h01};
  logic [15:0] sw [6] = '{16'h8220, 16'h4210, 16'h2208, 16'h0204,
                          16'h0202, 16'h1200};

  // Main sequence
  initial begin
    rstn = 1'b0;
    output_enable = 1'b0;
    multi_phase = 1'b0;
    busy_event = 1'b0;
    output_voltage_summary_meas = 16'h0000;
    foreach (st[i]) st[i] = 8'h00;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rc(CMD_TURN_OFF_DELAY, 16'hca80);
    rc(CMD_TURN_OFF_FALL_TIME, 16'hca80);
    rc(CMD_STATUS_SUMMARY_WORD, 16'h0840);
    rc(CMD_STATUS_SUMMARY_BYTE, 16'h0040);
    host.wr(CMD_STATUS_SUMMARY_BYTE, 16'hffff);
    host.wr(CMD_STATUS_SUMMARY_WORD, 16'hffff);
    chk({15'h0000, cmd_unknown}, 16'h0000);
    rc(CMD_STATUS_SUMMARY_WORD, 16'h0840);
    host.rd(8'h00, rd_d, rd_u, rd_v);
    chk({rd_d[15:1], rd_u}, 16'h0001);
    host.wr(8'h00, 16'h1234);
    chk({15'h0000, cmd_unknown}, 16'h0001);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      st[i] = pat[i];
      rc(CMD_STATUS_SUMMARY_WORD, sw[i] | 16'h0840);
      rc(CMD_STATUS_SUMMARY_BYTE, {8'h00, sw[i][7:0] | 8'h40});
      st[i] = 8'h00;
    end
    busy_event = 1'b1;
    @(negedge clk);
    busy_event = 1'b0;
    rc(CMD_STATUS_SUMMARY_WORD, 16'h08c0);
    rc(CMD_STATUS_SUMMARY_WORD, 16'h08c0);
    host.clr();
    rc(CMD_STATUS_SUMMARY_WORD, 16'h0840);
    fork
      host.clr();
      begin
        @(negedge clk);
        busy_event = 1'b1;
        @(negedge clk);
        busy_event = 1'b0;
      end
    join
    rc(CMD_STATUS_SUMMARY_WORD, 16'h08c0);
    host.clr();
    rc(CMD_STATUS_SUMMARY_WORD, 16'h0840);
    $display("test status done");
    host.wr(CMD_TURN_OFF_DELAY, 16'hf804);
    rc(CMD_TURN_OFF_DELAY, 16'hf804);
    sd(1'b1, 16'hca80, 1'b0);
    sd(1'b0, 16'hca80, 1'b1);
    sd(1'b0, 16'h0004, 1'b0);
    output_enable = 1'b1;
    repeat (2) @(negedge clk);
    output_enable = 1'b0;
    repeat (10) @(negedge clk);
    chk({15'h0000, ramp_active | switches_off}, 16'h0000);
    output_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk({14'h0000, output_off, switches_off}, 16'h0000);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    rc(CMD_TURN_OFF_DELAY, 16'hca80);
    rc(CMD_TURN_OFF_FALL_TIME, 16'hca80);
    $display("test abort and reset done");
    complete_run();
  end
endmodule // shutdown_status_regs_tb_top
